// ==== pcc_pkg.sv ====
`default_nettype none
package pcc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFS_MASTER_POWER = 8'h00;
  localparam logic [7:0] OFS_LOOP_CLOCK = 8'h01;
  localparam logic [7:0] OFS_BLOCK_POWER = 8'h04;
  localparam logic [7:0] RST_MASTER_POWER = 8'h00;
  localparam logic [7:0] RST_LOOP_CLOCK = 8'h41;
  localparam logic [7:0] RST_BLOCK_POWER = 8'h3f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned BIT_SOFT_RESET = 7;
  localparam int unsigned BIT_MASTER_POWER_ON = 0;
  localparam int unsigned BIT_LOOP_LOCKED = 7;
  localparam int unsigned BIT_UNLOCK_AUTOMUTE = 6;
  localparam int unsigned BIT_LOOP_REF_SELECT = 4;
  localparam int unsigned LSB_CLOCK_RATIO = 0;
  localparam int unsigned W_CLOCK_RATIO = 3;
  localparam int unsigned BIT_FRAME_CLOCK_POLARITY = 7;
  localparam int unsigned BIT_BIT_CLOCK_DATA_EDGE = 6;
  localparam int unsigned BIT_REGULATOR_ENABLE = 5;
  localparam int unsigned BIT_VREF_ENABLE = 4;
  localparam int unsigned LSB_CHANNEL_ENABLE = 0;
  localparam int unsigned NUM_CHANNELS = 4;
  // Clock ratio codes and multipliers
  localparam logic [2:0] RATIO_128 = 3'h0;
  localparam logic [2:0] RATIO_256 = 3'h1;
  localparam logic [2:0] RATIO_384 = 3'h2;
  localparam logic [2:0] RATIO_512 = 3'h3;
  localparam logic [2:0] RATIO_768 = 3'h4;
  localparam logic [9:0] MULT_128 = 10'h080;
  localparam logic [9:0] MULT_256 = 10'h100;
  localparam logic [9:0] MULT_384 = 10'h180;
  localparam logic [9:0] MULT_512 = 10'h200;
  localparam logic [9:0] MULT_768 = 10'h300;
endpackage
`default_nettype wire

// ==== pcc_ratio_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcc_ratio_decode
  import pcc_pkg::*;
(
  input wire logic [2:0] code_i,
  output logic [9:0] mult_o,
  output logic reserved_o
);
  always_comb begin
    reserved_o = 1'b0;
    case (code_i)
      RATIO_128: mult_o = MULT_128;
      RATIO_256: mult_o = MULT_256;
      RATIO_384: mult_o = MULT_384;
      RATIO_512: mult_o = MULT_512;
      RATIO_768: mult_o = MULT_768;
      default: begin
        // Reserved codes fall back to the reset ratio
        mult_o = MULT_256;
        reserved_o = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== pcc_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Writing 1 to soft-reset bit returns all logic and registers except the read-data register to defaults.
// - Master power-on bit 0 powers whole device down at 0, up at 1.
// - With master power on, each block still has its own enable.
// - Loop-locked flag is read-only, shows live lock state, resets to 0.
// - Unlock automute bit set mutes ADC data whenever loop loses lock.
// - Loop reference select: 0 master clock, 1 frame clock.
// - Clock ratio field picks 128,256,384,512,768 times; 5 to 7 reserved.
// - Bit 6 picks data edge, bit 7 frame-clock polarity.
// - Bit 5 enables regulator, bit 4 voltage reference, both reset 1.
// - Bits 3 to 0 enable channels 4 to 1, all reset 1.
module pcc_regs
  import pcc_pkg::*;
#(
  parameter int unsigned CHANNELS = NUM_CHANNELS
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [pcc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pcc_pkg::DATA_W-1:0] wdata_i,
  output logic [pcc_pkg::DATA_W-1:0] rdata_o,
  output logic addr_valid_o,
  input wire logic loop_locked_i,
  output logic core_reset_o,
  output logic master_power_on_o,
  output logic unlock_automute_o,
  output logic loop_ref_select_o,
  output logic [2:0] clock_ratio_select_o,
  output logic [9:0] loop_multiplier_o,
  output logic clock_ratio_reserved_o,
  output logic frame_clock_polarity_o,
  output logic bit_clock_data_edge_o,
  output logic regulator_enable_o,
  output logic vref_enable_o,
  output logic [CHANNELS-1:0] channel_enable_o,
  output logic adc_mute_o
);
  import pcc_pkg::*;

  if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
    $error("pcc_regs: only four channels are mapped");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] master_reg;
  logic [7:0] loop_reg;
  logic [7:0] block_reg;
  logic locked_reg;
  logic [7:0] rdata_reg;

  wire hit_master = (addr_i == OFS_MASTER_POWER);
  wire hit_loop = (addr_i == OFS_LOOP_CLOCK);
  wire hit_block = (addr_i == OFS_BLOCK_POWER);
  // Soft reset is a one-cycle self-clearing pulse, so the bit reads back 0
  wire soft_reset = wr_en_i & hit_master & wdata_i[BIT_SOFT_RESET];
  wire any_reset = srst_i | soft_reset;

  always_ff @(posedge clock_i) begin
    if (any_reset) begin
      master_reg <= RST_MASTER_POWER;
      loop_reg <= RST_LOOP_CLOCK;
      block_reg <= RST_BLOCK_POWER;
      locked_reg <= 1'b0;
    end else begin
      locked_reg <= loop_locked_i;
      if (wr_en_i && hit_master) begin
        master_reg <= wdata_i & ~(8'h01 << BIT_SOFT_RESET);
      end
      if (wr_en_i && hit_loop) begin
        loop_reg <= wdata_i & ~(8'h01 << BIT_LOOP_LOCKED);
      end
      if (wr_en_i && hit_block) begin
        block_reg <= wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Lock bit is the lock input registered one cycle, never written content
  wire [7:0] loop_view = loop_reg | ({7'h00, locked_reg} << BIT_LOOP_LOCKED);
  wire [7:0] rd_mux = hit_master ? master_reg :
                      hit_loop ? loop_view :
                      hit_block ? block_reg : 8'h00;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_en_i) begin
      rdata_reg <= rd_mux;
    end
  end

  assign rdata_o = rdata_reg;
  assign addr_valid_o = hit_master | hit_loop | hit_block;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  wire pwr = master_reg[BIT_MASTER_POWER_ON];
  wire [2:0] ratio_code = loop_reg[LSB_CLOCK_RATIO +: W_CLOCK_RATIO];

  assign core_reset_o = any_reset;
  assign master_power_on_o = pwr;
  assign unlock_automute_o = loop_reg[BIT_UNLOCK_AUTOMUTE];
  assign loop_ref_select_o = loop_reg[BIT_LOOP_REF_SELECT];
  assign clock_ratio_select_o = ratio_code;
  assign frame_clock_polarity_o = block_reg[BIT_FRAME_CLOCK_POLARITY];
  assign bit_clock_data_edge_o = block_reg[BIT_BIT_CLOCK_DATA_EDGE];
  // Block enables are gated by master power; any one can drop alone
  assign regulator_enable_o = pwr & block_reg[BIT_REGULATOR_ENABLE];
  assign vref_enable_o = pwr & block_reg[BIT_VREF_ENABLE];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      assign channel_enable_o[g] = pwr & block_reg[LSB_CHANNEL_ENABLE + g];
    end
  endgenerate

  // Mute follows the live lock input so no unlocked sample escapes
  assign adc_mute_o = unlock_automute_o & ~loop_locked_i;

  pcc_ratio_decode u_ratio (
    .code_i(ratio_code),
    .mult_o(loop_multiplier_o),
    .reserved_o(clock_ratio_reserved_o)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_soft_reset;
    @(posedge clock_i) disable iff (srst_i)
      soft_reset |=> (master_reg == RST_MASTER_POWER) && (loop_reg == RST_LOOP_CLOCK)
        && (block_reg == RST_BLOCK_POWER);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a register dirty");

  property p_power_gate;
    @(posedge clock_i) disable iff (srst_i)
      !master_power_on_o |-> (channel_enable_o == '0) && !regulator_enable_o && !vref_enable_o;
  endproperty
  a_power_gate: assert property (p_power_gate) else $error("block enabled while powered down");

  property p_block_alone;
    @(posedge clock_i) disable iff (srst_i)
      master_power_on_o |-> (channel_enable_o == block_reg[CHANNELS-1:0]);
  endproperty
  a_block_alone: assert property (p_block_alone) else $error("channel enable not independent");

  property p_lock_view;
    @(posedge clock_i) disable iff (srst_i || soft_reset)
      1'b1 |=> loop_view[BIT_LOOP_LOCKED] == $past(loop_locked_i);
  endproperty
  a_lock_view: assert property (p_lock_view) else $error("lock flag not live");

  property p_mute;
    @(posedge clock_i) disable iff (srst_i)
      (loop_reg[BIT_UNLOCK_AUTOMUTE] && !loop_locked_i) |-> adc_mute_o;
  endproperty
  a_mute: assert property (p_mute) else $error("unlock not muted");

  property p_no_mute;
    @(posedge clock_i) disable iff (srst_i)
      (!loop_reg[BIT_UNLOCK_AUTOMUTE] || loop_locked_i) |-> !adc_mute_o;
  endproperty
  a_no_mute: assert property (p_no_mute) else $error("spurious mute");

  property p_ref_write;
    @(posedge clock_i) disable iff (srst_i)
      (wr_en_i && hit_loop) |=> loop_ref_select_o == $past(wdata_i[BIT_LOOP_REF_SELECT]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference select not written");

  property p_ratio;
    @(posedge clock_i) disable iff (srst_i)
      (clock_ratio_select_o == RATIO_768) |-> (loop_multiplier_o == MULT_768) && !clock_ratio_reserved_o;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio decode wrong");

  property p_edges;
    @(posedge clock_i) disable iff (srst_i)
      (wr_en_i && hit_block && !soft_reset) |=>
        (bit_clock_data_edge_o == $past(wdata_i[6])) && (frame_clock_polarity_o == $past(wdata_i[7]));
  endproperty
  a_edges: assert property (p_edges) else $error("port edge bits not written");

  property p_reset_ones;
    @(posedge clock_i) srst_i |=> block_reg == RST_BLOCK_POWER;
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("block power reset wrong");

  property p_lock_write;
    @(posedge clock_i) disable iff (srst_i)
      (wr_en_i && hit_loop) |=> !loop_reg[BIT_LOOP_LOCKED];
  endproperty
  a_lock_write: assert property (p_lock_write) else $error("lock bit stored");

  property p_master_write;
    @(posedge clock_i) disable iff (srst_i)
      (wr_en_i && hit_master && !soft_reset) |=> master_power_on_o == $past(wdata_i[BIT_MASTER_POWER_ON]);
  endproperty
  a_master_write: assert property (p_master_write) else $error("master power bit not written");

  property p_lock_reset;
    @(posedge clock_i) srst_i |=> !loop_view[BIT_LOOP_LOCKED];
  endproperty
  a_lock_reset: assert property (p_lock_reset) else $error("lock flag not cleared by reset");

  c_soft_reset: cover property (@(posedge clock_i) soft_reset);
  c_mute: cover property (@(posedge clock_i) adc_mute_o);
  c_power_up: cover property (@(posedge clock_i) master_power_on_o && channel_enable_o != '0);
  c_reserved: cover property (@(posedge clock_i) clock_ratio_reserved_o);
  c_frame_source: cover property (@(posedge clock_i) loop_ref_select_o && adc_mute_o);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pcc_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic loop_locked_i = 1'b0;
  logic [7:0] rdata_o;
  logic addr_valid_o, core_reset_o, master_power_on_o, unlock_automute_o, loop_ref_select_o;
  logic [2:0] clock_ratio_select_o;
  logic [9:0] loop_multiplier_o;
  logic [9:0] mult;
  logic clock_ratio_reserved_o, frame_clock_polarity_o, bit_clock_data_edge_o;
  logic regulator_enable_o, vref_enable_o, adc_mute_o;
  logic [3:0] channel_enable_o;
  int err_total = 0;
  int n_compared = 0;
  // Address, write data, expected read back
  logic [7:0] rows [6][3] = '{'{8'h00, 8'h01, 8'h01}, '{8'h04, 8'hc5, 8'hc5}, '{8'h01, 8'h13, 8'h13},
                              '{8'h01, 8'hc2, 8'h42}, '{8'h02, 8'h55, 8'h00}, '{8'h04, 8'h3a, 8'h3a}};

  always #20 clock_i = ~clock_i;

  pcc_regs i_pcc_regs (.clock_i(clock_i), .srst_i(srst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .addr_valid_o(addr_valid_o),
    .loop_locked_i(loop_locked_i), .core_reset_o(core_reset_o), .master_power_on_o(master_power_on_o),
    .unlock_automute_o(unlock_automute_o), .loop_ref_select_o(loop_ref_select_o),
    .clock_ratio_select_o(clock_ratio_select_o), .loop_multiplier_o(loop_multiplier_o),
    .clock_ratio_reserved_o(clock_ratio_reserved_o), .frame_clock_polarity_o(frame_clock_polarity_o),
    .bit_clock_data_edge_o(bit_clock_data_edge_o), .regulator_enable_o(regulator_enable_o),
    .vref_enable_o(vref_enable_o), .channel_enable_o(channel_enable_o), .adc_mute_o(adc_mute_o));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Strobe dropped a full cycle before the next access, so no double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge clock_i);
    wr_en_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i = a;
    rd_en_i = 1'b1;
    @(negedge clock_i);
    rd_en_i = 1'b0;
    @(negedge clock_i);
    chk({2'h0, rdata_o}, {2'h0, exp}, "read data");
  endtask

  task automatic check_defaults();
    rd(OFS_MASTER_POWER, 8'h00);
    rd(OFS_LOOP_CLOCK, 8'h41);
    rd(OFS_BLOCK_POWER, 8'h3f);
    chk({4'h0, regulator_enable_o, vref_enable_o, channel_enable_o}, 10'h000, "gated enables");
    chk({7'h0, unlock_automute_o, loop_ref_select_o, adc_mute_o}, 10'h005, "loop defaults");
    chk(loop_multiplier_o, MULT_256, "default ratio");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Guard against a hang
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    check_defaults();
    for (int r = 0; r < 6; r++) begin
      wr(rows[r][0], rows[r][1]);
      rd(rows[r][0], rows[r][2]);
    end
    chk({2'h0, frame_clock_polarity_o, bit_clock_data_edge_o, regulator_enable_o, vref_enable_o,
         channel_enable_o}, 10'h03a, "port edges and enables");
    addr_i = 8'h02;
    #1 chk({9'h0, addr_valid_o}, 10'h000, "unmapped hit");
    @(negedge clock_i);
    addr_i = OFS_LOOP_CLOCK;
    #1 chk({9'h0, addr_valid_o}, 10'h001, "mapped hit");
    @(negedge clock_i);
    wr(OFS_MASTER_POWER, 8'h00);
    chk({3'h0, master_power_on_o, regulator_enable_o, vref_enable_o, channel_enable_o}, 10'h000, "master off");
    wr(OFS_MASTER_POWER, 8'h01);
    chk({3'h0, master_power_on_o, regulator_enable_o, vref_enable_o, channel_enable_o}, 10'h07a, "master on");
    // Every ratio code, reserved ones decode to 256
    for (int c = 0; c < 8; c++) begin
      wr(OFS_LOOP_CLOCK, 8'h40 | 8'(c));
      case (c)
        0: mult = MULT_128;
        2: mult = MULT_384;
        3: mult = MULT_512;
        4: mult = MULT_768;
        default: mult = MULT_256;
      endcase
      chk(loop_multiplier_o, mult, "multiplier");
      chk({6'h0, clock_ratio_reserved_o, clock_ratio_select_o}, 10'(c) | ((c > 4) ? 10'h8 : 10'h0),
          "ratio code");
    end
    wr(OFS_LOOP_CLOCK, 8'h51);
    chk({9'h0, loop_ref_select_o}, 10'h001, "frame clock source");
    chk({9'h0, adc_mute_o}, 10'h001, "mute while unlocked");
    loop_locked_i = 1'b1;
    #1 chk({9'h0, adc_mute_o}, 10'h000, "no mute when locked");
    @(negedge clock_i);
    rd(OFS_LOOP_CLOCK, 8'hd1);
    wr(OFS_LOOP_CLOCK, 8'h11);
    rd(OFS_LOOP_CLOCK, 8'h91);
    loop_locked_i = 1'b0;
    @(negedge clock_i);
    chk({9'h0, adc_mute_o}, 10'h000, "automute off");
    rd(OFS_LOOP_CLOCK, 8'h11);
    // Soft reset in mid-run, pulse seen in the write cycle
    addr_i = OFS_MASTER_POWER;
    wdata_i = 8'h81;
    wr_en_i = 1'b1;
    #1 chk({9'h0, core_reset_o}, 10'h001, "soft reset pulse");
    @(negedge clock_i);
    wr_en_i = 1'b0;
    @(negedge clock_i);
    check_defaults();
    wr(OFS_BLOCK_POWER, 8'hc0);
    chk({8'h0, frame_clock_polarity_o, bit_clock_data_edge_o}, 10'h003, "port edge bits set");
    srst_i = 1'b1;
    @(negedge clock_i);
    srst_i = 1'b0;
    chk({2'h0, rdata_o}, 10'h000, "read data after reset");
    check_defaults();
    wrap_up();
  end
endmodule
`default_nettype wire
